/* File: pmbus_bank_pkg.sv */
package pmbus_bank_pkg;

	localparam logic [7:0] CMD_OUTPUT_ON_OFF = 8'h01;
	localparam logic [7:0] CMD_ON_OFF_SOURCE = 8'h02;
	localparam logic [7:0] CMD_FAULT_CLEAR = 8'h03;
	localparam logic [7:0] CMD_WRITE_LOCK = 8'h10;
	localparam logic [7:0] CMD_STORE_DEFAULTS = 8'h11;
	localparam logic [7:0] CMD_RESTORE_DEFAULTS = 8'h12;
	localparam logic [7:0] CMD_STORE_USER = 8'h15;
	localparam logic [7:0] CMD_RESTORE_USER = 8'h16;
	localparam logic [7:0] CMD_FEATURE_REPORT = 8'h19;
	localparam logic [7:0] CMD_ALERT_MASK = 8'h1b;
	localparam logic [7:0] CMD_DATA_FORMAT = 8'h20;
	localparam logic [7:0] CMD_SETPOINT = 8'h21;
	localparam logic [7:0] CMD_UPPER_CLAMP = 8'h24;
	localparam logic [7:0] CMD_SLEW_RATE = 8'h27;
	localparam logic [7:0] CMD_SENSE_RATIO = 8'h29;
	localparam logic [7:0] CMD_LOWER_CLAMP = 8'h2b;
	localparam logic [7:0] CMD_START_THRESHOLD = 8'h35;
	localparam logic [7:0] CMD_STOP_THRESHOLD = 8'h36;

	localparam logic [7:0] RESET_OUTPUT_ON_OFF = 8'h00;
	localparam logic [7:0] RESET_ON_OFF_SOURCE = 8'h16;
	localparam logic [7:0] RESET_WRITE_LOCK = 8'h00;
	localparam logic [7:0] RESET_ALERT_MASK = 8'h08;
	localparam logic [7:0] FEATURE_REPORT_VALUE = 8'hb0;
	localparam logic [7:0] DATA_FORMAT_VALUE = 8'h17;
	localparam logic [15:0] RESET_SETPOINT = 16'h0133;
	localparam logic [15:0] RESET_SLEW_RATE = 16'hd03c;
	localparam logic [15:0] RESET_SENSE_RATIO = 16'hf004;
	localparam logic [15:0] RESET_START_THRESHOLD = 16'hf012;
	localparam logic [15:0] RESET_STOP_THRESHOLD = 16'hf010;

	// sense ratio codes and the clamp words they restore
	localparam logic [15:0] RATIO_ONE = 16'hf004;
	localparam logic [15:0] RATIO_HALF = 16'hf002;
	localparam logic [15:0] RATIO_QUARTER = 16'hf001;
	localparam logic [15:0] UPPER_RATIO_ONE = 16'h034d;
	localparam logic [15:0] UPPER_RATIO_HALF = 16'h069a;
	localparam logic [15:0] UPPER_RATIO_QUARTER = 16'h0c00;
	localparam logic [15:0] LOWER_RATIO_ONE = 16'h00b3;
	localparam logic [15:0] LOWER_RATIO_HALF = 16'h0166;
	localparam logic [15:0] LOWER_RATIO_QUARTER = 16'h02cc;

	// source config fields and on/off command output bit
	localparam int SRC_USE_SETTINGS_BIT = 4;
	localparam int SRC_NEED_COMMAND_BIT = 3;
	localparam int SRC_NEED_PIN_BIT = 2;
	localparam int SRC_PIN_HIGH_BIT = 1;
	localparam int OUTPUT_ON_BIT = 7;

	// write lock levels
	localparam logic [7:0] LOCK_NONE = 8'h00;
	localparam logic [7:0] LOCK_ALL = 8'h80;
	localparam logic [7:0] LOCK_ALLOW_ON_OFF = 8'h40;
	localparam logic [7:0] LOCK_ALLOW_SETPOINT = 8'h20;

	// fault status bit positions
	localparam int POWER_GOOD_STATUS_BIT = 3;
	localparam int COMM_FAULT_BIT = 1;

	localparam logic [6:0] ALERT_RESPONSE_ADDRESS = 7'h0c;
	localparam logic [6:0] DEFAULT_DEVICE_ADDRESS = 7'h24;

	localparam logic [1:0] LEN_SEND = 2'h0;
	localparam logic [1:0] LEN_BYTE = 2'h1;
	localparam logic [1:0] LEN_WORD = 2'h2;
	localparam logic [1:0] LEN_NONE = 2'h3;

	typedef enum logic [5:0] {
		PH_IDLE = 6'h01,
		PH_ADDR = 6'h02,
		PH_CMD = 6'h04,
		PH_WDATA = 6'h08,
		PH_RDATA = 6'h10,
		PH_ARA = 6'h20
	} link_phase_type;

	typedef struct packed {
		logic write;
		logic has_cmd;
		logic [7:0] cmd;
		logic [1:0] count;
		logic [15:0] data;
	} link_frame_type;

	typedef struct packed {
		logic [7:0] on_off_source;
		logic [7:0] write_lock;
		logic [7:0] alert_mask;
		logic [15:0] setpoint;
		logic [15:0] sense_ratio;
		logic [15:0] start_threshold;
		logic [15:0] stop_threshold;
	} nvm_image_type;

endpackage

/* File: pmbus_command_register_bank.sv */
`timescale 1ns/1ns

// Function
// - fault clear zeroes status, releases alert
// - source config picks pin, command, both
// - on/off command resets zero, bit 7 gates output
// - write lock gates writes, resets open
// - store commands copy settings to nvm
// - restore commands reload settings from nvm
// - feature report fixed read-only byte
// - alert mask gates alert, not status, power-good masked
// - data format fixed read-only byte
// - upper clamp limits setpoint, ratio restores
// - lower clamp limits setpoint, ratio restores
// - slew rate word, default 0.9375 mV/us
// - sense ratio word selects restored clamps
// - start threshold word, default 4.5 V
// - stop threshold word, default 4 V
// - setpoint word resets to 600 mV
// - control pin polarity selectable
// - auto release alert after alert response
module pmbus_command_register_bank #(
	parameter logic [6:0] DEVICE_ADDRESS = pmbus_bank_pkg::DEFAULT_DEVICE_ADDRESS
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	output logic alert_out,
	output logic alert_oe_n,
	input wire logic enable_control_pin,
	input wire logic auto_alert_release_enable,
	input wire logic [7:0] fault_event,
	output logic regulation_enable,
	output logic [15:0] regulation_target,
	output logic [15:0] slew_rate,
	output logic [15:0] sense_ratio,
	output logic [15:0] start_threshold,
	output logic [15:0] stop_threshold,
	output logic [7:0] fault_status
);

	function automatic logic [1:0] cmd_length(input logic [7:0] cmd);
		case (cmd)
			pmbus_bank_pkg::CMD_FAULT_CLEAR, pmbus_bank_pkg::CMD_STORE_DEFAULTS,
			pmbus_bank_pkg::CMD_RESTORE_DEFAULTS, pmbus_bank_pkg::CMD_STORE_USER,
			pmbus_bank_pkg::CMD_RESTORE_USER: cmd_length = pmbus_bank_pkg::LEN_SEND;
			pmbus_bank_pkg::CMD_OUTPUT_ON_OFF, pmbus_bank_pkg::CMD_ON_OFF_SOURCE,
			pmbus_bank_pkg::CMD_WRITE_LOCK,
			pmbus_bank_pkg::CMD_ALERT_MASK: cmd_length = pmbus_bank_pkg::LEN_BYTE;
			pmbus_bank_pkg::CMD_SETPOINT, pmbus_bank_pkg::CMD_UPPER_CLAMP,
			pmbus_bank_pkg::CMD_SLEW_RATE, pmbus_bank_pkg::CMD_SENSE_RATIO,
			pmbus_bank_pkg::CMD_LOWER_CLAMP, pmbus_bank_pkg::CMD_START_THRESHOLD,
			pmbus_bank_pkg::CMD_STOP_THRESHOLD: cmd_length = pmbus_bank_pkg::LEN_WORD;
			default: cmd_length = pmbus_bank_pkg::LEN_NONE;
		endcase
	endfunction

	function automatic logic lock_allows(input logic [7:0] lock, input logic [7:0] cmd);
		case (lock)
			pmbus_bank_pkg::LOCK_NONE: lock_allows = 1'b1;
			pmbus_bank_pkg::LOCK_ALL: lock_allows = (cmd == pmbus_bank_pkg::CMD_WRITE_LOCK);
			pmbus_bank_pkg::LOCK_ALLOW_ON_OFF: lock_allows =
				(cmd == pmbus_bank_pkg::CMD_WRITE_LOCK) ||
				(cmd == pmbus_bank_pkg::CMD_OUTPUT_ON_OFF);
			pmbus_bank_pkg::LOCK_ALLOW_SETPOINT: lock_allows =
				(cmd == pmbus_bank_pkg::CMD_WRITE_LOCK) ||
				(cmd == pmbus_bank_pkg::CMD_OUTPUT_ON_OFF) ||
				(cmd == pmbus_bank_pkg::CMD_ON_OFF_SOURCE) ||
				(cmd == pmbus_bank_pkg::CMD_SETPOINT);
			default: lock_allows = (cmd == pmbus_bank_pkg::CMD_WRITE_LOCK);
		endcase
	endfunction

	function automatic logic [15:0] clamp_for_ratio(input logic [15:0] ratio, input logic upper);
		case (ratio)
			pmbus_bank_pkg::RATIO_HALF: clamp_for_ratio = upper ?
				pmbus_bank_pkg::UPPER_RATIO_HALF : pmbus_bank_pkg::LOWER_RATIO_HALF;
			pmbus_bank_pkg::RATIO_QUARTER: clamp_for_ratio = upper ?
				pmbus_bank_pkg::UPPER_RATIO_QUARTER : pmbus_bank_pkg::LOWER_RATIO_QUARTER;
			default: clamp_for_ratio = upper ?
				pmbus_bank_pkg::UPPER_RATIO_ONE : pmbus_bank_pkg::LOWER_RATIO_ONE;
		endcase
	endfunction

	// ---------------- link side, on the serial clock ----------------
	logic start_tog;
	logic stop_tog;
	logic start_seen;
	logic [3:0] bit_cnt;
	logic [7:0] shreg;
	logic [7:0] rx_byte;
	logic ack_now;
	logic rd_idx;
	logic cmd_tog;
	logic ara_tog;
	logic [1:0] alert_link_sync;
	pmbus_bank_pkg::link_phase_type phase;
	pmbus_bank_pkg::link_frame_type frame;
	logic [15:0] rd_word;
	logic [7:0] tx_byte;

	// start: data falls while clock high; stop: data rises while clock high
	always_ff @(negedge sda_in or negedge nrst) begin
		if (!nrst) begin
			start_tog <= 1'b0;
		end else if (scl_in) begin
			start_tog <= ~start_tog;
		end
	end

	always_ff @(posedge sda_in or negedge nrst) begin
		if (!nrst) begin
			stop_tog <= 1'b0;
		end else if (scl_in) begin
			stop_tog <= ~stop_tog;
		end
	end

	always_ff @(posedge scl_in or negedge nrst) begin
		if (!nrst) begin
			alert_link_sync <= 2'h0;
		end else begin
			alert_link_sync <= {alert_link_sync[0], ~alert_oe_n};
		end
	end

	assign rx_byte = {shreg[6:0], sda_in};

	always_ff @(posedge scl_in or negedge nrst) begin
		if (!nrst) begin
			start_seen <= 1'b0;
			bit_cnt <= 4'h0;
			shreg <= 8'h00;
			ack_now <= 1'b0;
			rd_idx <= 1'b0;
			cmd_tog <= 1'b0;
			ara_tog <= 1'b0;
			phase <= pmbus_bank_pkg::PH_IDLE;
			frame <= '0;
		end else if (start_tog != start_seen) begin
			start_seen <= start_tog;
			bit_cnt <= 4'h1;
			shreg <= {7'h00, sda_in};
			ack_now <= 1'b0;
			frame.write <= 1'b0;
			phase <= pmbus_bank_pkg::PH_ADDR;
		end else if (phase != pmbus_bank_pkg::PH_IDLE) begin
			if (bit_cnt < 4'h8) begin
				shreg <= rx_byte;
				bit_cnt <= bit_cnt + 4'h1;
			end
			if (bit_cnt == 4'h7) begin
				ack_now <= 1'b0;
				case (phase)
					pmbus_bank_pkg::PH_ADDR: begin
						if (rx_byte[7:1] == DEVICE_ADDRESS) begin
							ack_now <= 1'b1;
							frame.write <= ~rx_byte[0];
							if (!rx_byte[0]) begin
								frame.has_cmd <= 1'b0;
								frame.count <= 2'h0;
							end
						end else if (rx_byte[7:1] == pmbus_bank_pkg::ALERT_RESPONSE_ADDRESS
							&& rx_byte[0] && alert_link_sync[1]) begin
							ack_now <= 1'b1;
						end
					end
					pmbus_bank_pkg::PH_CMD: begin
						ack_now <= 1'b1;
						frame.cmd <= rx_byte;
						frame.has_cmd <= 1'b1;
						cmd_tog <= ~cmd_tog;
					end
					pmbus_bank_pkg::PH_WDATA: begin
						ack_now <= 1'b1;
						if (frame.count == 2'h0) begin
							frame.data[7:0] <= rx_byte;
						end
						if (frame.count == 2'h1) begin
							frame.data[15:8] <= rx_byte;
						end
						if (frame.count != 2'h3) begin
							frame.count <= frame.count + 2'h1;
						end
					end
					default: begin
						ack_now <= 1'b0;
					end
				endcase
			end
			if (bit_cnt == 4'h8) begin
				bit_cnt <= 4'h0;
				ack_now <= 1'b0;
				case (phase)
					pmbus_bank_pkg::PH_ADDR: begin
						rd_idx <= 1'b0;
						if (!ack_now) begin
							phase <= pmbus_bank_pkg::PH_IDLE;
						end else if (shreg[7:1] == pmbus_bank_pkg::ALERT_RESPONSE_ADDRESS) begin
							phase <= pmbus_bank_pkg::PH_ARA;
						end else if (shreg[0]) begin
							phase <= pmbus_bank_pkg::PH_RDATA;
						end else begin
							phase <= pmbus_bank_pkg::PH_CMD;
						end
					end
					pmbus_bank_pkg::PH_CMD: phase <= pmbus_bank_pkg::PH_WDATA;
					pmbus_bank_pkg::PH_WDATA: phase <= pmbus_bank_pkg::PH_WDATA;
					pmbus_bank_pkg::PH_RDATA: begin
						rd_idx <= ~rd_idx;
						if (sda_in) begin
							phase <= pmbus_bank_pkg::PH_IDLE;
						end
					end
					pmbus_bank_pkg::PH_ARA: begin
						ara_tog <= ~ara_tog;
						phase <= pmbus_bank_pkg::PH_IDLE;
					end
					default: phase <= pmbus_bank_pkg::PH_IDLE;
				endcase
			end
		end
	end

	assign tx_byte = (phase == pmbus_bank_pkg::PH_ARA) ? {DEVICE_ADDRESS, 1'b0} :
		(rd_idx ? rd_word[15:8] : rd_word[7:0]);

	// data and acknowledge change only while the clock is low
	always_ff @(negedge scl_in or negedge nrst) begin
		if (!nrst) begin
			sda_oe_n <= 1'b1;
		end else if ((phase == pmbus_bank_pkg::PH_RDATA || phase == pmbus_bank_pkg::PH_ARA)
			&& bit_cnt < 4'h8) begin
			sda_oe_n <= tx_byte[3'(4'h7 - bit_cnt)];
		end else begin
			sda_oe_n <= ~(bit_cnt == 4'h8 && ack_now);
		end
	end

	assign sda_out = 1'b0;
	assign alert_out = 1'b0;

	// ---------------- register side, on clk ----------------
	logic [2:0] stop_sync;
	logic [2:0] cmd_sync;
	logic [2:0] ara_sync;
	logic [1:0] pin_sync;
	logic stop_edge;
	logic [7:0] rd_cmd;
	logic [15:0] next_rd_word;
	logic [7:0] output_on_off;
	logic [7:0] on_off_source;
	logic [7:0] write_lock;
	logic [7:0] alert_mask;
	logic [15:0] setpoint;
	logic [15:0] upper_clamp;
	logic [15:0] lower_clamp;
	pmbus_bank_pkg::nvm_image_type nvm_image;
	pmbus_bank_pkg::nvm_image_type live_image;
	logic [1:0] len;
	logic len_ok;
	logic commit;
	logic do_write;
	logic bad_write;
	logic do_clear;
	logic do_store;
	logic do_restore;
	logic pin_active;
	logic alert_released;
	logic [7:0] status_set;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stop_sync <= 3'h0;
			cmd_sync <= 3'h0;
			ara_sync <= 3'h0;
			pin_sync <= 2'h0;
		end else begin
			stop_sync <= {stop_sync[1:0], stop_tog};
			cmd_sync <= {cmd_sync[1:0], cmd_tog};
			ara_sync <= {ara_sync[1:0], ara_tog};
			pin_sync <= {pin_sync[0], enable_control_pin};
		end
	end

	assign stop_edge = stop_sync[2] ^ stop_sync[1];

	// command code is stable long before the toggle lands
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rd_cmd <= 8'h00;
			rd_word <= 16'h0000;
		end else begin
			if (cmd_sync[2] ^ cmd_sync[1]) begin
				rd_cmd <= frame.cmd;
			end
			rd_word <= next_rd_word;
		end
	end

	always_comb begin
		case (rd_cmd)
			pmbus_bank_pkg::CMD_OUTPUT_ON_OFF: next_rd_word = {8'h00, output_on_off};
			pmbus_bank_pkg::CMD_ON_OFF_SOURCE: next_rd_word = {8'h00, on_off_source};
			pmbus_bank_pkg::CMD_WRITE_LOCK: next_rd_word = {8'h00, write_lock};
			pmbus_bank_pkg::CMD_FEATURE_REPORT:
				next_rd_word = {8'h00, pmbus_bank_pkg::FEATURE_REPORT_VALUE};
			pmbus_bank_pkg::CMD_ALERT_MASK: next_rd_word = {8'h00, alert_mask};
			pmbus_bank_pkg::CMD_DATA_FORMAT:
				next_rd_word = {8'h00, pmbus_bank_pkg::DATA_FORMAT_VALUE};
			pmbus_bank_pkg::CMD_SETPOINT: next_rd_word = setpoint;
			pmbus_bank_pkg::CMD_UPPER_CLAMP: next_rd_word = upper_clamp;
			pmbus_bank_pkg::CMD_SLEW_RATE: next_rd_word = slew_rate;
			pmbus_bank_pkg::CMD_SENSE_RATIO: next_rd_word = sense_ratio;
			pmbus_bank_pkg::CMD_LOWER_CLAMP: next_rd_word = lower_clamp;
			pmbus_bank_pkg::CMD_START_THRESHOLD: next_rd_word = start_threshold;
			pmbus_bank_pkg::CMD_STOP_THRESHOLD: next_rd_word = stop_threshold;
			default: next_rd_word = 16'h0000;
		endcase
	end

	// frame is settled after stop: the clock stands still until next start
	assign len = cmd_length(frame.cmd);
	assign len_ok = (len == pmbus_bank_pkg::LEN_SEND) ? (frame.count == 2'h0) :
		(len == pmbus_bank_pkg::LEN_BYTE) ? (frame.count != 2'h0) :
		(len == pmbus_bank_pkg::LEN_WORD) ? (frame.count[1] == 1'b1) : 1'b0;
	assign commit = stop_edge && frame.write && frame.has_cmd;
	assign do_clear = commit && len_ok && frame.cmd == pmbus_bank_pkg::CMD_FAULT_CLEAR;
	assign do_store = commit && len_ok && (frame.cmd == pmbus_bank_pkg::CMD_STORE_DEFAULTS ||
		frame.cmd == pmbus_bank_pkg::CMD_STORE_USER);
	assign do_restore = commit && len_ok && write_lock == pmbus_bank_pkg::LOCK_NONE &&
		(frame.cmd == pmbus_bank_pkg::CMD_RESTORE_DEFAULTS ||
		frame.cmd == pmbus_bank_pkg::CMD_RESTORE_USER);
	assign do_write = commit && len_ok && len != pmbus_bank_pkg::LEN_SEND &&
		lock_allows(write_lock, frame.cmd);
	assign bad_write = commit && !(do_clear || do_store || do_restore || do_write);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			output_on_off <= pmbus_bank_pkg::RESET_OUTPUT_ON_OFF;
			on_off_source <= pmbus_bank_pkg::RESET_ON_OFF_SOURCE;
			write_lock <= pmbus_bank_pkg::RESET_WRITE_LOCK;
			alert_mask <= pmbus_bank_pkg::RESET_ALERT_MASK;
			setpoint <= pmbus_bank_pkg::RESET_SETPOINT;
			upper_clamp <= pmbus_bank_pkg::UPPER_RATIO_ONE;
			lower_clamp <= pmbus_bank_pkg::LOWER_RATIO_ONE;
			slew_rate <= pmbus_bank_pkg::RESET_SLEW_RATE;
			sense_ratio <= pmbus_bank_pkg::RESET_SENSE_RATIO;
			start_threshold <= pmbus_bank_pkg::RESET_START_THRESHOLD;
			stop_threshold <= pmbus_bank_pkg::RESET_STOP_THRESHOLD;
		end else if (do_restore) begin
			on_off_source <= nvm_image.on_off_source;
			write_lock <= nvm_image.write_lock;
			alert_mask <= nvm_image.alert_mask;
			setpoint <= nvm_image.setpoint;
			sense_ratio <= nvm_image.sense_ratio;
			start_threshold <= nvm_image.start_threshold;
			stop_threshold <= nvm_image.stop_threshold;
			upper_clamp <= clamp_for_ratio(nvm_image.sense_ratio, 1'b1);
			lower_clamp <= clamp_for_ratio(nvm_image.sense_ratio, 1'b0);
		end else if (do_write) begin
			case (frame.cmd)
				pmbus_bank_pkg::CMD_OUTPUT_ON_OFF: output_on_off <= frame.data[7:0];
				pmbus_bank_pkg::CMD_ON_OFF_SOURCE: on_off_source <= frame.data[7:0];
				pmbus_bank_pkg::CMD_WRITE_LOCK: write_lock <= frame.data[7:0];
				pmbus_bank_pkg::CMD_ALERT_MASK: alert_mask <= frame.data[7:0];
				pmbus_bank_pkg::CMD_SETPOINT: setpoint <= frame.data;
				pmbus_bank_pkg::CMD_UPPER_CLAMP: upper_clamp <= frame.data;
				pmbus_bank_pkg::CMD_SLEW_RATE: slew_rate <= frame.data;
				pmbus_bank_pkg::CMD_SENSE_RATIO: sense_ratio <= frame.data;
				pmbus_bank_pkg::CMD_LOWER_CLAMP: lower_clamp <= frame.data;
				pmbus_bank_pkg::CMD_START_THRESHOLD: start_threshold <= frame.data;
				pmbus_bank_pkg::CMD_STOP_THRESHOLD: stop_threshold <= frame.data;
				default: output_on_off <= output_on_off;
			endcase
		end
	end

	assign live_image = '{on_off_source, write_lock, alert_mask, setpoint, sense_ratio,
		start_threshold, stop_threshold};

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			nvm_image <= '{pmbus_bank_pkg::RESET_ON_OFF_SOURCE,
				pmbus_bank_pkg::RESET_WRITE_LOCK, pmbus_bank_pkg::RESET_ALERT_MASK,
				pmbus_bank_pkg::RESET_SETPOINT, pmbus_bank_pkg::RESET_SENSE_RATIO,
				pmbus_bank_pkg::RESET_START_THRESHOLD, pmbus_bank_pkg::RESET_STOP_THRESHOLD};
		end else if (do_store) begin
			nvm_image <= live_image;
		end
	end

	// output enable from source config
	assign pin_active = on_off_source[pmbus_bank_pkg::SRC_PIN_HIGH_BIT] ?
		pin_sync[1] : ~pin_sync[1];

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			regulation_enable <= 1'b0;
			regulation_target <= pmbus_bank_pkg::RESET_SETPOINT;
		end else begin
			regulation_enable <= on_off_source[pmbus_bank_pkg::SRC_USE_SETTINGS_BIT] ?
				((~on_off_source[pmbus_bank_pkg::SRC_NEED_COMMAND_BIT] |
				output_on_off[pmbus_bank_pkg::OUTPUT_ON_BIT]) &
				(~on_off_source[pmbus_bank_pkg::SRC_NEED_PIN_BIT] | pin_active)) :
				1'b1;
			if (setpoint > upper_clamp) begin
				regulation_target <= upper_clamp;
			end else if (setpoint < lower_clamp) begin
				regulation_target <= lower_clamp;
			end else begin
				regulation_target <= setpoint;
			end
		end
	end

	// status: a set in the clearing cycle survives
	always_comb begin
		status_set = fault_event;
		status_set[pmbus_bank_pkg::COMM_FAULT_BIT] =
			fault_event[pmbus_bank_pkg::COMM_FAULT_BIT] | bad_write;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fault_status <= 8'h00;
		end else begin
			fault_status <= (do_clear ? 8'h00 : fault_status) | status_set;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			alert_released <= 1'b0;
			alert_oe_n <= 1'b1;
		end else begin
			if (|(status_set & ~alert_mask)) begin
				alert_released <= 1'b0;
			end else if ((ara_sync[2] ^ ara_sync[1]) && auto_alert_release_enable) begin
				alert_released <= 1'b1;
			end else if (do_clear) begin
				alert_released <= 1'b0;
			end
			alert_oe_n <= ~((|(fault_status & ~alert_mask)) && !alert_released &&
				!do_clear);
		end
	end

endmodule

/* File: pmbus_bank_chk_sva.sv */
`timescale 1ns/1ns
module pmbus_bank_chk (
	input wire logic clk,
	input wire logic nrst,
	input wire logic auto_alert_release_enable,
	input wire logic [7:0] fault_event,
	input wire logic alert_oe_n,
	input wire logic [15:0] regulation_target,
	input wire logic [15:0] slew_rate,
	input wire logic [15:0] sense_ratio,
	input wire logic [15:0] start_threshold,
	input wire logic [15:0] stop_threshold,
	input wire logic [7:0] fault_status
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	chk_reset_target: assert property ($rose(nrst) |-> regulation_target == 16'h0133)
		else $error("setpoint reset wrong");
	chk_reset_slew: assert property ($rose(nrst) |-> slew_rate == 16'hd03c)
		else $error("slew reset wrong");
	chk_reset_limits: assert property ($rose(nrst) |-> sense_ratio == 16'hf004
		&& start_threshold == 16'hf012 && stop_threshold == 16'hf010)
		else $error("limit reset wrong");
	chk_status_sticky: assert property (fault_event != 8'h00
		|=> (fault_status & $past(fault_event)) == $past(fault_event))
		else $error("status bit not set");
	chk_clear_all: assert property (((~fault_status & $past(fault_status)) != 8'h00)
		|-> ((fault_status & ~$past(fault_event)) == 8'h00))
		else $error("partial status clear");
	chk_idle_release: assert property ((fault_status == 8'h00)[*3] |-> alert_oe_n)
		else $error("alert held without status");
	chk_alert_unmasked: assert property (fault_event[1] |-> ##[1:4] !alert_oe_n)
		else $error("unmasked event no alert");
	chk_pgood_masked: assert property ((fault_event == 8'h08
		&& fault_status == 8'h00 && alert_oe_n) |=> alert_oe_n[*4])
		else $error("masked event raised alert");
	chk_auto_release: assert property (($rose(alert_oe_n) && !auto_alert_release_enable)
		|-> ##[0:3] (fault_status == 8'h00))
		else $error("alert released early");
endmodule
bind pmbus_command_register_bank pmbus_bank_chk u_chk (.clk, .nrst, .auto_alert_release_enable,
	.fault_event, .alert_oe_n, .regulation_target, .slew_rate, .sense_ratio, .start_threshold,
	.stop_threshold, .fault_status);

/* File: pmbus_host_model.sv */
`timescale 1ns/1ns
module pmbus_host_model #(
	parameter logic [6:0] ADDR = pmbus_bank_pkg::DEFAULT_DEVICE_ADDRESS
) (
	output logic scl,
	output logic sda_low,
	input wire logic sda
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic start();
		scl = 1'b0;
		#1 sda_low = 1'b0;
		#2 scl = 1'b1;
		#3 sda_low = 1'b1;
		#3;
	endtask
	// idle gap lets the device commit before the next frame
	task automatic stop();
		scl = 1'b0;
		#1 sda_low = 1'b1;
		#2 scl = 1'b1;
		#3 sda_low = 1'b0;
		#1100;
	endtask
	task automatic bit_io(input logic b, output logic r);
		scl = 1'b0;
		#1 sda_low = !b;
		#2 scl = 1'b1;
		#2 r = sda;
		#1;
	endtask
	task automatic xfer(input logic [7:0] tx, input logic ack, output logic [7:0] rx);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], rx[i]);
		end
		bit_io(ack, a);
	endtask
	task automatic wr(input logic [7:0] cmd, input int n, input logic [15:0] d);
		logic [7:0] r;
		start();
		xfer({ADDR, 1'b0}, 1'b1, r);
		xfer(cmd, 1'b1, r);
		for (int i = 0; i < n; i++) begin
			xfer(d[8*i+:8], 1'b1, r);
		end
		stop();
	endtask
	// never used on write-only codes
	task automatic rd(input logic [7:0] cmd, output logic [15:0] d);
		logic [7:0] r;
		start();
		xfer({ADDR, 1'b0}, 1'b1, r);
		xfer(cmd, 1'b1, r);
		#600;
		start();
		xfer({ADDR, 1'b1}, 1'b1, r);
		xfer(8'hff, 1'b0, d[7:0]);
		xfer(8'hff, 1'b1, d[15:8]);
		stop();
	endtask
	task automatic ara(output logic [7:0] b);
		logic [7:0] r;
		start();
		xfer({pmbus_bank_pkg::ALERT_RESPONSE_ADDRESS, 1'b1}, 1'b1, r);
		xfer(8'hff, 1'b1, b);
		stop();
	endtask
endmodule

/* File: tb.sv */
`timescale 1ns/1ns
module tb;
	logic clk, nrst, pin, auto_rel, scl, host_low, sda_oe_n, alert_oe_n, reg_en;
	logic [7:0] fault_event, st, b8, c;
	logic [15:0] rd, lf, v, slew, ratio, von, voff, target;
	wire logic sda = !(host_low || !sda_oe_n);
	int n_mismatch = 0;
	int checks = 0;
	logic [7:0] codes [13] = '{8'h01, 8'h02, 8'h10, 8'h19, 8'h1b, 8'h20, 8'h21, 8'h24, 8'h27,
		8'h29, 8'h2b, 8'h35, 8'h36};
	logic [15:0] dflt [13] = '{16'h0, 16'h16, 16'h0, 16'hb0, 16'h08, 16'h17, 16'h0133, 16'h034d,
		16'hd03c, 16'hf004, 16'h00b3, 16'hf012, 16'hf010};
	logic [7:0] bad [4] = '{8'h19, 8'h20, 8'h05, 8'h21};
	pmbus_command_register_bank u_dut (.clk, .nrst, .scl_in(scl), .sda_in(sda), .sda_out(),
		.sda_oe_n, .alert_out(), .alert_oe_n, .enable_control_pin(pin),
		.auto_alert_release_enable(auto_rel), .fault_event, .regulation_enable(reg_en),
		.regulation_target(target), .slew_rate(slew), .sense_ratio(ratio),
		.start_threshold(von), .stop_threshold(voff), .fault_status(st));
	pmbus_host_model u_host (.scl, .sda_low(host_low), .sda);
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	function automatic logic [15:0] clamp(input logic [15:0] x);
		return x < 16'h00b3 ? 16'h00b3 : x > 16'h034d ? 16'h034d : x;
	endfunction
	function automatic logic en_exp(input logic [7:0] cf, input logic op, input logic p);
		return (!cf[3] || op) && (!cf[2] || p == cf[1]);
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic pulse(input logic [7:0] e);
		@(negedge clk) fault_event = e;
		@(negedge clk) fault_event = 8'h00;
		repeat (4) @(negedge clk);
	endtask
	task automatic close_out();
		$display("mismatches=%0d checks=%0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#500000;
		n_mismatch++;
		close_out();
	end
	initial begin
		nrst = 1'b0;
		pin = 1'b0;
		auto_rel = 1'b1;
		fault_event = 8'h00;
		lf = 16'h0025;
		repeat (2) @(negedge clk);
		nrst = 1'b1;
		repeat (10) @(negedge clk);
		check({15'h0, reg_en}, 16'h0000);
		foreach (codes[i]) begin
			u_host.rd(codes[i], rd);
			check(rd, dflt[i]);
		end
		for (int i = 0; i < 6; i++) begin
			lf = lfsr(lf);
			v = i == 0 ? 16'h00b2 : i == 1 ? 16'h034e : i == 2 ? 16'h0200 : lf;
			u_host.wr(8'h27, 2, lf);
			check(slew, lf);
			u_host.wr(8'h35, 2, ~lf);
			check(von, ~lf);
			u_host.wr(8'h36, 2, lf ^ 16'h5a5a);
			check(voff, lf ^ 16'h5a5a);
			u_host.wr(8'h21, 2, v);
			check(target, clamp(v));
		end
		foreach (bad[i]) begin
			u_host.wr(bad[i], 1, 16'h0055);
			check({st[1], 14'h0, alert_oe_n}, 16'h8000);
			u_host.wr(8'h03, 0, 16'h0);
			check({st, 7'h0, alert_oe_n}, 16'h0001);
		end
		u_host.rd(8'h19, rd);
		check(rd, 16'h00b0);
		u_host.rd(8'h21, rd);
		check(rd, v);
		u_host.wr(8'h10, 1, 16'h0080);
		u_host.wr(8'h27, 2, 16'h1111);
		check({slew[14:0], st[1]}, {lf[14:0], 1'b1});
		u_host.wr(8'h10, 1, 16'h0000);
		u_host.wr(8'h03, 0, 16'h0);
		for (int i = 0; i < 12; i++) begin
			lf = lfsr(lf);
			c = {3'h0, 1'b1, lf[2] | !lf[1], lf[1], lf[0], 1'b0};
			u_host.wr(8'h02, 1, {8'h0, c});
			u_host.wr(8'h01, 1, {8'h0, lf[7], 7'h0});
			@(negedge clk) pin = lf[8];
			repeat (8) @(negedge clk);
			check({15'h0, reg_en}, {15'h0, en_exp(c, lf[7], lf[8])});
		end
		for (int i = 0; i < 2; i++) begin
			u_host.wr(8'h29, 2, i ? 16'hf001 : 16'hf002);
			u_host.wr(8'h35, 2, 16'hf012);
			u_host.wr(i ? 8'h15 : 8'h11, 0, 16'h0);
			u_host.wr(8'h35, 2, 16'h1234);
			u_host.wr(8'h29, 2, 16'hf004);
			u_host.wr(i ? 8'h16 : 8'h12, 0, 16'h0);
			check(von, 16'hf012);
			check(ratio, i ? 16'hf001 : 16'hf002);
			u_host.rd(8'h24, rd);
			check(rd, i ? 16'h0c00 : 16'h069a);
			u_host.rd(8'h2b, rd);
			check(rd, i ? 16'h02cc : 16'h0166);
		end
		for (int i = 1; i >= 0; i--) begin
			@(negedge clk) auto_rel = i[0];
			pulse(8'h02);
			check({15'h0, alert_oe_n}, 16'h0000);
			u_host.ara(b8);
			check({8'h0, b8}, {8'h0, pmbus_bank_pkg::DEFAULT_DEVICE_ADDRESS, 1'b0});
			check({15'h0, alert_oe_n}, {15'h0, i[0]});
			u_host.wr(8'h03, 0, 16'h0);
			check({st, 7'h0, alert_oe_n}, 16'h0001);
		end
		pulse(8'h08);
		check({st, 7'h0, alert_oe_n}, 16'h0801);
		close_out();
	end
endmodule
